// ---- hmb_pkg.sv ----
// Shared constants and types for the multiplexed host register port.
`default_nettype none
package hmb_pkg;
   // Bus style select: split read/write strobes or one strobe with a direction line.
   typedef enum logic {
      HMB_STYLE_SPLIT = 1'b0,
      HMB_STYLE_DIRSTB = 1'b1
   } hmb_style_e;

   // Device register locations inside the 256-byte space.
   localparam logic [7:0] HMB_REQ_ADDR = 8'h10;
   localparam logic [7:0] HMB_MASK_ADDR = 8'h11;
   localparam logic [7:0] HMB_CLR_ADDR = 8'h12;
   localparam logic [7:0] HMB_ERREN_ADDR = 8'h13;
   localparam logic [7:0] HMB_CMD6_ADDR = 8'hF3;

   // Field positions.
   localparam int HMB_ERREN_TX_BIT = 0;
   localparam int HMB_ERREN_DPLL_BIT = 1;
   localparam int HMB_ERREN_RX_BIT = 2;
   localparam int HMB_CMD6_RAUX_BIT = 0;
   localparam int HMB_CMD6_TAUX_LSB = 1;
   localparam int HMB_CMD6_NEW_LSB = 4;

   // Values after reset, and the fixed value that the clear register reads back.
   localparam logic [7:0] HMB_MASK_RST = 8'hFF;
   localparam logic [7:0] HMB_ZERO_RST = 8'h00;
   localparam logic [7:0] HMB_CLR_READ = 8'hFF;

   // Host-side command register offsets and control bits.
   localparam logic [2:0] HMB_HC_ADDR = 3'h0;
   localparam logic [2:0] HMB_HC_WDATA = 3'h1;
   localparam logic [2:0] HMB_HC_CTRL = 3'h2;
   localparam logic [2:0] HMB_HC_STATUS = 3'h3;
   localparam logic [2:0] HMB_HC_RDATA = 3'h4;
   localparam int HMB_CTRL_GO_WR_BIT = 0;
   localparam int HMB_CTRL_GO_RD_BIT = 1;
   localparam int HMB_CTRL_STYLE_BIT = 2;
   localparam int HMB_CTRL_RST_BIT = 3;

   // Bus phase timing on the host side.
   localparam int HMB_CLK_NS = 8;
   localparam int HMB_PHASE_NS = 48;
   localparam int HMB_PHASE_CYC = (HMB_PHASE_NS + HMB_CLK_NS - 1) / HMB_CLK_NS;
endpackage
`default_nettype wire

// ---- hmb_if.sv ----
// Pin-level carrier joining the host controller and the register device.
`default_nettype none
interface hmb_if;
   logic [7:0] ad_host_out;
   logic ad_host_oe;
   logic [7:0] ad_dev_out;
   logic ad_dev_oe;
   logic [7:0] ad;
   logic ale;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic host_bus_style_select;
   logic dev_rst_n;
   logic irq_out_n_oe;
   logic irq_out_n;

   // Pull-up: an undriven bus reads as all ones.
   assign ad = ad_dev_oe ? ad_dev_out : (ad_host_oe ? ad_host_out : 8'hFF);
   // Open drain with pull-up.
   assign irq_out_n = ~irq_out_n_oe;

   modport dev (
      input ad, ale, cs_n, rd_n, wr_n, host_bus_style_select, dev_rst_n,
      output ad_dev_out, ad_dev_oe, irq_out_n_oe
   );
   modport host (
      input ad, irq_out_n,
      output ad_host_out, ad_host_oe, ale, cs_n, rd_n, wr_n, host_bus_style_select, dev_rst_n
   );
endinterface
`default_nettype wire

// ---- hmb_device.sv ----
// Register device end of the multiplexed host port, with interrupt and reset effects.
//
// Our own choices: the address-and-strobe port and the register offsets.
`default_nettype none
// Function
// R1 - Style select picks split or direction strobes
// R2 - Latch address on falling latch strobe
// R3 - Host raises latch strobe, then lowers it
// R4 - Data phase carries the latched register
// R5 - Cycles accepted only while select is low; the address latch here does not check select
// R6 - Select rising completes transfer, releases bus
// R7 - Style 0: read strobe for reads only
// R8 - Style 0: write strobe for writes only
// R9 - Style 1: read pin strobes both directions
// R10 - Style 1: write pin gives direction
// R11 - Interrupt low when unmasked request pending
// R12 - Interrupt holds until requests cleared by zeros
// R13 - Host resets only after power and clock
// R14 - Registers stay accessible during device reset
// R15 - Device reset leaves other registers untouched
// R16 - Device reset sets all mask bits
// R17 - Device reset clears three error enables
// R18 - Device reset clears auxiliary enables
// R19 - Device reset clears newly added command bits
// R20 - Auxiliary receive enable steers shared pins
// R21 - Synchronize select, strobes and latch inputs
module hmb_device (
   input wire logic clk_sys,
   input wire logic rst,
   hmb_if.dev bus,
   input wire logic [7:0] irq_event,
   output logic aux_receive_enable,
   output logic [2:0] aux_transmit_enable,
   output logic tx_error_irq_enable,
   output logic clock_recovery_error_irq_enable,
   output logic rx_error_irq_enable,
   output logic [7:0] interrupt_request_bits,
   output logic [7:0] interrupt_mask_bits
);

   // Control pins in one vector: {dev_rst_n, wr_n, rd_n, ale, cs_n}.
   logic [4:0] ctl_s1_q;
   logic [4:0] ctl_s2_q;
   logic [4:0] ctl_s3_q;
   logic [7:0] ad_s1_q;
   logic [7:0] ad_s2_q;
   logic style_q;

   logic [7:0] addr_q;
   logic [7:0] wdata_q;
   logic [7:0] req_q;
   logic [7:0] mask_q;
   logic [7:0] erren_q;
   logic [7:0] cmd6_q;
   logic [7:0] mem_q [256];
   logic [7:0] ad_out_q;
   logic ad_oe_q;
   logic irq_oe_q;

   logic cs_now;
   logic cs_prev;
   logic rd_now;
   logic wr_now;
   logic wr_prev;
   logic ale_fall;
   logic cs_rise;
   logic dev_rst_fall;
   logic wr_commit;
   logic [7:0] rd_mux;
   logic [7:0] clr_bits;
   logic [1:0] dec_now;
   logic [1:0] dec_prev;

   // Decodes {write_active, read_active} from the strobe pair and bus style.
   function automatic logic [1:0] strobe_dec(input logic style, input logic rd_n,
                                             input logic wr_n);
      logic [1:0] res;
      res = 2'b00;
      if (style == hmb_pkg::HMB_STYLE_DIRSTB) begin // R1
         res[0] = ~rd_n & wr_n; // R9 R10
         res[1] = ~rd_n & ~wr_n; // R9 R10
      end else begin
         res[0] = ~rd_n; // R7
         res[1] = ~wr_n; // R8
      end
      return res;
   endfunction

   // Two-stage synchronizers, third stage only for edge detection.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // The latch strobe idles low; resetting it high would fake a fall after reset.
         ctl_s1_q <= 5'h1D;
         ctl_s2_q <= 5'h1D;
         ctl_s3_q <= 5'h1D;
      end else begin
         ctl_s1_q <= {bus.dev_rst_n, bus.wr_n, bus.rd_n, bus.ale, bus.cs_n}; // R21
         ctl_s2_q <= ctl_s1_q; // R21
         ctl_s3_q <= ctl_s2_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ad_s1_q <= 8'h00;
         ad_s2_q <= 8'h00;
      end else begin
         ad_s1_q <= bus.ad;
         ad_s2_q <= ad_s1_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         style_q <= hmb_pkg::HMB_STYLE_SPLIT;
      end else begin
         style_q <= bus.host_bus_style_select; // R1
      end
   end

   always_comb begin
      cs_now = ~ctl_s2_q[0]; // R5
      cs_prev = ~ctl_s3_q[0];
      dec_now = strobe_dec(style_q, ctl_s2_q[2], ctl_s2_q[3]);
      dec_prev = strobe_dec(style_q, ctl_s3_q[2], ctl_s3_q[3]);
      rd_now = dec_now[0] & cs_now; // R5
      wr_now = dec_now[1] & cs_now; // R5
      wr_prev = dec_prev[1] & cs_prev;
      ale_fall = ctl_s3_q[1] & ~ctl_s2_q[1]; // R2
      cs_rise = cs_prev & ~cs_now;
      dev_rst_fall = ctl_s3_q[4] & ~ctl_s2_q[4];
      // A write ends when its strobe rises or when select rises under it.
      wr_commit = wr_prev & (~wr_now | cs_rise); // R6
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         addr_q <= 8'h00;
      end else if (ale_fall) begin
         addr_q <= ad_s2_q; // R2
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wdata_q <= 8'h00;
      end else if (wr_now) begin
         wdata_q <= ad_s2_q; // R4
      end
   end

   always_comb begin
      clr_bits = 8'h00;
      if (wr_commit && addr_q == hmb_pkg::HMB_CLR_ADDR) begin
         clr_bits = ~wdata_q; // R12
      end
   end

   // A new event wins over a clear in the same cycle.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         req_q <= hmb_pkg::HMB_ZERO_RST;
      end else begin
         req_q <= (req_q & ~clr_bits) | irq_event; // R12
      end
   end

   // Device reset forces bits at its assertion edge so writes still land while it is held.
   always_ff @(posedge clk_sys) begin
      if (rst || dev_rst_fall) begin
         mask_q <= hmb_pkg::HMB_MASK_RST; // R16
      end else if (wr_commit && addr_q == hmb_pkg::HMB_MASK_ADDR) begin
         mask_q <= wdata_q; // R14
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         erren_q <= hmb_pkg::HMB_ZERO_RST;
      end else if (dev_rst_fall) begin
         erren_q[hmb_pkg::HMB_ERREN_TX_BIT] <= 1'b0; // R17
         erren_q[hmb_pkg::HMB_ERREN_DPLL_BIT] <= 1'b0; // R17
         erren_q[hmb_pkg::HMB_ERREN_RX_BIT] <= 1'b0; // R17
      end else if (wr_commit && addr_q == hmb_pkg::HMB_ERREN_ADDR) begin
         erren_q <= wdata_q; // R14
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmd6_q <= hmb_pkg::HMB_ZERO_RST;
      end else if (dev_rst_fall) begin
         cmd6_q[hmb_pkg::HMB_CMD6_RAUX_BIT] <= 1'b0; // R18
         cmd6_q[hmb_pkg::HMB_CMD6_TAUX_LSB +: 3] <= 3'h0; // R18
         cmd6_q[hmb_pkg::HMB_CMD6_NEW_LSB +: 4] <= 4'h0; // R19
      end else if (wr_commit && addr_q == hmb_pkg::HMB_CMD6_ADDR) begin
         cmd6_q <= wdata_q; // R14
      end
   end

   // Plain storage keeps its contents through both resets.
   always_ff @(posedge clk_sys) begin
      if (wr_commit) begin
         mem_q[addr_q] <= wdata_q; // R15
      end
   end

   always_comb begin
      unique case (addr_q)
         hmb_pkg::HMB_REQ_ADDR: rd_mux = req_q;
         hmb_pkg::HMB_MASK_ADDR: rd_mux = mask_q;
         hmb_pkg::HMB_CLR_ADDR: rd_mux = hmb_pkg::HMB_CLR_READ;
         hmb_pkg::HMB_ERREN_ADDR: rd_mux = erren_q;
         hmb_pkg::HMB_CMD6_ADDR: rd_mux = cmd6_q;
         default: rd_mux = mem_q[addr_q];
      endcase
   end

   // Drive the bus only for a selected read; select high always releases it.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ad_oe_q <= 1'b0;
         ad_out_q <= 8'h00;
      end else if (rd_now) begin
         ad_oe_q <= 1'b1; // R4
         ad_out_q <= rd_mux; // R4
      end else begin
         ad_oe_q <= 1'b0; // R6
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_oe_q <= 1'b0;
      end else begin
         irq_oe_q <= |(req_q & ~mask_q); // R11
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aux_receive_enable <= 1'b0;
         aux_transmit_enable <= 3'h0;
         tx_error_irq_enable <= 1'b0;
         clock_recovery_error_irq_enable <= 1'b0;
         rx_error_irq_enable <= 1'b0;
         interrupt_request_bits <= hmb_pkg::HMB_ZERO_RST;
         interrupt_mask_bits <= hmb_pkg::HMB_MASK_RST;
      end else begin
         aux_receive_enable <= cmd6_q[hmb_pkg::HMB_CMD6_RAUX_BIT]; // R20
         aux_transmit_enable <= cmd6_q[hmb_pkg::HMB_CMD6_TAUX_LSB +: 3];
         tx_error_irq_enable <= erren_q[hmb_pkg::HMB_ERREN_TX_BIT];
         clock_recovery_error_irq_enable <= erren_q[hmb_pkg::HMB_ERREN_DPLL_BIT];
         rx_error_irq_enable <= erren_q[hmb_pkg::HMB_ERREN_RX_BIT];
         interrupt_request_bits <= req_q;
         interrupt_mask_bits <= mask_q;
      end
   end

   assign bus.ad_dev_out = ad_out_q;
   assign bus.ad_dev_oe = ad_oe_q;
   assign bus.irq_out_n_oe = irq_oe_q;

endmodule // hmb_device
`default_nettype wire

// ---- hmb_host.sv ----
// Host controller end: runs multiplexed bus cycles ordered through a small register port.
`default_nettype none
module hmb_host (
   input wire logic clk_sys,
   input wire logic rst,
   hmb_if.host bus,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);

   typedef enum logic [2:0] {
      HMB_ST_IDLE = 3'b000,
      HMB_ST_ADDR = 3'b001,
      HMB_ST_LATCH = 3'b010,
      HMB_ST_STROBE = 3'b011,
      HMB_ST_RELEASE = 3'b100,
      HMB_ST_END = 3'b101
   } hmb_hstate_e;

   localparam logic [7:0] PHASE_LAST = 8'(hmb_pkg::HMB_PHASE_CYC - 1);

   hmb_hstate_e state_q;
   logic [7:0] tick_q;
   logic [7:0] taddr_q;
   logic [7:0] tdata_q;
   logic [7:0] result_q;
   logic is_read_q;
   logic style_q;
   logic hold_rst_q;
   logic ale_q;
   logic cs_n_q;
   logic rd_n_q;
   logic wr_n_q;
   logic [7:0] ad_out_q;
   logic ad_oe_q;
   logic phase_end;
   logic go_wr;
   logic go_rd;

   assign phase_end = (tick_q == PHASE_LAST);
   assign go_wr = reg_wr && reg_addr == hmb_pkg::HMB_HC_CTRL &&
                  reg_wdata[hmb_pkg::HMB_CTRL_GO_WR_BIT];
   assign go_rd = reg_wr && reg_addr == hmb_pkg::HMB_HC_CTRL &&
                  reg_wdata[hmb_pkg::HMB_CTRL_GO_RD_BIT] && !go_wr;

   // Phase divider: one enable pulse per bus phase.
   always_ff @(posedge clk_sys) begin
      if (rst || state_q == HMB_ST_IDLE || phase_end) begin
         tick_q <= 8'h00;
      end else begin
         tick_q <= tick_q + 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         taddr_q <= 8'h00;
         tdata_q <= 8'h00;
         style_q <= hmb_pkg::HMB_STYLE_SPLIT;
         hold_rst_q <= 1'b0;
      end else if (reg_wr && reg_addr == hmb_pkg::HMB_HC_ADDR) begin
         taddr_q <= reg_wdata;
      end else if (reg_wr && reg_addr == hmb_pkg::HMB_HC_WDATA) begin
         tdata_q <= reg_wdata;
      end else if (reg_wr && reg_addr == hmb_pkg::HMB_HC_CTRL && state_q == HMB_ST_IDLE) begin
         style_q <= reg_wdata[hmb_pkg::HMB_CTRL_STYLE_BIT]; // R1
         hold_rst_q <= reg_wdata[hmb_pkg::HMB_CTRL_RST_BIT]; // R13
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= HMB_ST_IDLE;
         is_read_q <= 1'b0;
         ale_q <= 1'b0;
         cs_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         ad_out_q <= 8'h00;
         ad_oe_q <= 1'b0;
         result_q <= 8'h00;
      end else begin
         unique case (state_q)
            HMB_ST_IDLE: begin
               if (go_wr || go_rd) begin
                  is_read_q <= go_rd;
                  state_q <= HMB_ST_ADDR;
                  ale_q <= 1'b1; // R3
                  ad_out_q <= taddr_q;
                  ad_oe_q <= 1'b1;
               end
            end
            HMB_ST_ADDR: begin
               if (phase_end) begin
                  state_q <= HMB_ST_LATCH;
                  ale_q <= 1'b0; // R3
                  cs_n_q <= 1'b0; // R5
                  if (style_q == hmb_pkg::HMB_STYLE_DIRSTB) begin
                     wr_n_q <= is_read_q; // R10
                  end
               end
            end
            HMB_ST_LATCH: begin
               if (phase_end) begin
                  state_q <= HMB_ST_STROBE;
                  ad_out_q <= tdata_q;
                  ad_oe_q <= !is_read_q; // R4
                  if (style_q == hmb_pkg::HMB_STYLE_DIRSTB || is_read_q) begin
                     rd_n_q <= 1'b0; // R7 R9
                  end else begin
                     wr_n_q <= 1'b0; // R8
                  end
               end
            end
            HMB_ST_STROBE: begin
               if (phase_end) begin
                  state_q <= HMB_ST_RELEASE;
                  rd_n_q <= 1'b1;
                  if (style_q == hmb_pkg::HMB_STYLE_SPLIT) begin
                     wr_n_q <= 1'b1;
                  end
                  if (is_read_q) begin
                     result_q <= bus.ad; // R4
                  end
               end
            end
            HMB_ST_RELEASE: begin
               if (phase_end) begin
                  state_q <= HMB_ST_END;
                  cs_n_q <= 1'b1; // R6
                  wr_n_q <= 1'b1;
                  ad_oe_q <= 1'b0;
               end
            end
            HMB_ST_END: begin
               if (phase_end) begin
                  state_q <= HMB_ST_IDLE;
               end
            end
            default: begin
               state_q <= HMB_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            hmb_pkg::HMB_HC_ADDR: reg_rdata <= taddr_q;
            hmb_pkg::HMB_HC_WDATA: reg_rdata <= tdata_q;
            hmb_pkg::HMB_HC_CTRL: reg_rdata <= {4'h0, hold_rst_q, style_q, 2'b00};
            hmb_pkg::HMB_HC_STATUS: reg_rdata <= {5'h00, hold_rst_q, ~bus.irq_out_n,
                                                  state_q != HMB_ST_IDLE}; // R11
            hmb_pkg::HMB_HC_RDATA: reg_rdata <= result_q;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   assign bus.ad_host_out = ad_out_q;
   assign bus.ad_host_oe = ad_oe_q;
   assign bus.ale = ale_q;
   assign bus.cs_n = cs_n_q;
   assign bus.rd_n = rd_n_q;
   assign bus.wr_n = wr_n_q;
   assign bus.host_bus_style_select = style_q;
   assign bus.dev_rst_n = ~hold_rst_q;

endmodule // hmb_host
`default_nettype wire

// ---- hmb_checker.sv ----
// Concurrent checks on the pins between the host controller and the register device.
`default_nettype none
module hmb_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ad_host_oe,
   input wire logic ad_dev_oe,
   input wire logic ale,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic host_bus_style_select,
   input wire logic irq_out_n
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   reset_quiet_a: assert property (disable iff (1'b0) rst |=> !ad_dev_oe && cs_n && !ale)
      else $error("pins not released after reset");
   drive_cause_a: assert property ($rose(ad_dev_oe) |-> !cs_n && !rd_n && wr_n)
      else $error("device drove bus without a read strobe");
   write_no_drive_a: assert property (!wr_n |-> !ad_dev_oe)
      else $error("device drove bus during a write");
   release_bound_a: assert property ($rose(cs_n) |-> ##[0:6] !ad_dev_oe)
      else $error("bus not released after select rose");
   idle_release_a: assert property (cs_n [*8] |-> !ad_dev_oe)
      else $error("device drove bus while not selected");
   no_contention_a: assert property (!(ad_dev_oe && ad_host_oe))
      else $error("both ends drive the bus");
   strobe_framed_a: assert property (!rd_n |-> !cs_n)
      else $error("read strobe outside select");
   latch_drive_a: assert property ($fell(ale) |-> $past(ad_host_oe) && $past(cs_n))
      else $error("address latch without address");

   cover property (!host_bus_style_select && !wr_n);
   cover property (host_bus_style_select && $rose(ad_dev_oe));
   cover property ($fell(irq_out_n));
endmodule // hmb_checker
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench: host controller and register device joined by the carrier.
`default_nettype none
`define tb_chk(act, exp) \
   begin checked++; if ((act) !== (exp)) begin err_count++; \
   $display("mismatch at %0t: got %h want %h", $time, act, exp); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] irq_event = 8'h00;
   logic aux_rx;
   logic [2:0] aux_tx;
   logic [2:0] err_en;
   logic [7:0] mask_bits;
   logic [7:0] req_bits;
   // Style and reset-hold bits carried into every control write.
   logic [7:0] ctrl_q = 8'h00;
   int err_count = 0;
   int checked = 0;

   always #4 clk_sys = ~clk_sys;

   hmb_if hmb_if_inst ();
   hmb_host hmb_host_inst (.clk_sys(clk_sys), .rst(rst), .bus(hmb_if_inst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   hmb_device hmb_device_inst (.clk_sys(clk_sys), .rst(rst), .bus(hmb_if_inst),
      .irq_event(irq_event), .aux_receive_enable(aux_rx), .aux_transmit_enable(aux_tx),
      .tx_error_irq_enable(err_en[0]), .clock_recovery_error_irq_enable(err_en[1]),
      .rx_error_irq_enable(err_en[2]), .interrupt_request_bits(req_bits),
      .interrupt_mask_bits(mask_bits));
   hmb_checker hmb_checker_inst (.clk_sys(clk_sys), .rst(rst),
      .ad_host_oe(hmb_if_inst.ad_host_oe), .ad_dev_oe(hmb_if_inst.ad_dev_oe),
      .ale(hmb_if_inst.ale), .cs_n(hmb_if_inst.cs_n), .rd_n(hmb_if_inst.rd_n),
      .wr_n(hmb_if_inst.wr_n), .host_bus_style_select(hmb_if_inst.host_bus_style_select),
      .irq_out_n(hmb_if_inst.irq_out_n));

   task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic wait_idle;
      logic [7:0] s;
      repeat (2) @(posedge clk_sys);
      for (int i = 0; i < 200; i++) begin
         reg_read(hmb_pkg::HMB_HC_STATUS, s);
         if (s[0] === 1'b0) return;
      end
      err_count++;
      $display("mismatch at %0t: host stuck busy", $time);
      end_of_test();
   endtask

   task automatic dev_write(input logic [7:0] a, input logic [7:0] d);
      reg_write(hmb_pkg::HMB_HC_ADDR, a);
      reg_write(hmb_pkg::HMB_HC_WDATA, d);
      reg_write(hmb_pkg::HMB_HC_CTRL, ctrl_q | 8'h01);
      wait_idle();
   endtask

   task automatic dev_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      reg_write(hmb_pkg::HMB_HC_ADDR, a);
      reg_write(hmb_pkg::HMB_HC_CTRL, ctrl_q | 8'h02);
      wait_idle();
      reg_read(hmb_pkg::HMB_HC_RDATA, d);
      `tb_chk(d, e)
   endtask

   task automatic pulse(input logic [7:0] e);
      @(posedge clk_sys);
      irq_event <= e;
      @(posedge clk_sys);
      irq_event <= 8'h00;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic t_irq;
      logic [7:0] s;
      pulse(8'h01);
      `tb_chk(hmb_if_inst.irq_out_n, 1'b1)
      dev_write(hmb_pkg::HMB_MASK_ADDR, 8'hFC);
      `tb_chk(hmb_if_inst.irq_out_n, 1'b0)
      pulse(8'h06);
      `tb_chk(req_bits, 8'h07)
      dev_chk(hmb_pkg::HMB_REQ_ADDR, 8'h07);
      dev_write(hmb_pkg::HMB_CLR_ADDR, 8'hFE);
      dev_chk(hmb_pkg::HMB_REQ_ADDR, 8'h06);
      `tb_chk(hmb_if_inst.irq_out_n, 1'b0)
      reg_read(hmb_pkg::HMB_HC_STATUS, s);
      `tb_chk(s[1], 1'b1)
      dev_write(hmb_pkg::HMB_CLR_ADDR, 8'hFD);
      `tb_chk(hmb_if_inst.irq_out_n, 1'b1)
      dev_write(hmb_pkg::HMB_MASK_ADDR, 8'hF8);
      `tb_chk(hmb_if_inst.irq_out_n, 1'b0)
      dev_chk(hmb_pkg::HMB_CLR_ADDR, hmb_pkg::HMB_CLR_READ);
      dev_write(hmb_pkg::HMB_CLR_ADDR, 8'h00);
      dev_chk(hmb_pkg::HMB_REQ_ADDR, 8'h00);
      `tb_chk(req_bits, 8'h00)
      `tb_chk(hmb_if_inst.irq_out_n, 1'b1)
      $display("test irq done");
   endtask

   task automatic t_styles;
      for (int s = 0; s < 2; s++) begin
         ctrl_q[2] = s[0];
         dev_write(8'h00, 8'h5A + 8'(s));
         dev_write(8'hFF, 8'hC3 - 8'(s));
         dev_chk(8'h00, 8'h5A + 8'(s));
         dev_chk(8'hFF, 8'hC3 - 8'(s));
         `tb_chk(hmb_if_inst.host_bus_style_select, s[0])
      end
      $display("test styles done");
   endtask

   task automatic t_dev_reset;
      dev_write(hmb_pkg::HMB_MASK_ADDR, 8'h00);
      dev_write(hmb_pkg::HMB_ERREN_ADDR, 8'h07);
      dev_write(hmb_pkg::HMB_CMD6_ADDR, 8'hFF);
      dev_write(8'h20, 8'hA5);
      `tb_chk({aux_tx, aux_rx, err_en}, 7'h7F)
      ctrl_q[3] = 1'b1;
      reg_write(hmb_pkg::HMB_HC_CTRL, ctrl_q);
      repeat (8) @(posedge clk_sys);
      `tb_chk(hmb_if_inst.dev_rst_n, 1'b0)
      dev_chk(hmb_pkg::HMB_MASK_ADDR, 8'hFF);
      dev_chk(hmb_pkg::HMB_ERREN_ADDR, 8'h00);
      dev_chk(hmb_pkg::HMB_CMD6_ADDR, 8'h00);
      dev_chk(8'h20, 8'hA5);
      `tb_chk({mask_bits, aux_tx, aux_rx, err_en}, 15'h7F80)
      dev_write(hmb_pkg::HMB_CMD6_ADDR, 8'h01);
      dev_chk(hmb_pkg::HMB_CMD6_ADDR, 8'h01);
      `tb_chk(aux_rx, 1'b1)
      ctrl_q[3] = 1'b0;
      reg_write(hmb_pkg::HMB_HC_CTRL, ctrl_q);
      dev_chk(hmb_pkg::HMB_CMD6_ADDR, 8'h01);
      $display("test device reset done");
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      reg_write(3'h7, 8'hFF);
      t_irq();
      t_styles();
      t_dev_reset();
      end_of_test();
   end

   initial begin
      #400000;
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
